//--- verilog/sram_test_defines.vh
// Constants for the packet SRAM test-access block: offsets, fields, resets.
// Assumes inclusion by bare name from the design files; definitions only.
//
// Notes on behaviour
// RULE_01 - Bit 13 of dma_control enables software access to the packet SRAM.
// RULE_02 - sram_test_address holds a 10-bit location field, words 0x000 to 0x3ff.
// RULE_03 - In test mode a write of sram_test_data stores into the selected word.
// RULE_04 - In test mode a read of sram_test_data returns the selected word.
// RULE_05 - Clearing bit 13 leaves test mode and returns the SRAM to the controller.
// RULE_06 - Software zeroes every word before receiving, avoiding false parity errors.
`ifndef SRAM_TEST_DEFINES_VH
`define SRAM_TEST_DEFINES_VH

// ************************************************************
// Register offsets (byte addresses, 12-bit decode)
// ************************************************************
`define OFF_DMA_CONTROL 12'h000
`define OFF_SRAM_TEST_ADDRESS 12'h060
`define OFF_SRAM_TEST_DATA 12'h064
`define OFF_IRQ_STATUS 12'h070
`define OFF_IRQ_MASK 12'h074

// ************************************************************
// Fields and reset values
// ************************************************************
`define BIT_TEST_ENABLE 13
`define LOC_MSB 9
`define SRAM_WORDS 1024
`define RST_DMA_CONTROL 32'h0000_0000
`define RST_LOCATION 10'h000
`define RST_IRQ_MASK 2'h0
`define IRQ_BITS 2
`define IRQ_BIT_WRITE_DONE 0
`define IRQ_BIT_REFUSED 1

`endif

//--- verilog/sram_word_store.v
// Packet SRAM model as flip-flops, one synchronous write port, async read.
// Assumes a single clock; caller selects the owner of the ports.
`timescale 1ns/10ps
`include "sram_test_defines.vh"

module sram_word_store
(
  input wire pclk,
  input wire write_en,
  input wire [`LOC_MSB:0] write_addr,
  input wire [31:0] write_data,
  input wire [`LOC_MSB:0] read_addr,
  output wire [31:0] read_data
);

  reg [31:0] mem [0:`SRAM_WORDS-1];

  // Word write; contents are undefined until software clears them
  always @(posedge pclk)
  begin
    if (write_en)
      mem[write_addr] <= write_data;
  end

  // Combinational read by index
  assign read_data = mem[read_addr];

endmodule // sram_word_store

//--- verilog/ether_sram_test_access.v
// Test-mode access path into the Ethernet packet SRAM, APB slave.
// Assumes an APB master on pclk; controller port is used when test mode is off.
`timescale 1ns/10ps
`include "sram_test_defines.vh"

module ether_sram_test_access
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire ctrl_write_en,
  input wire [`LOC_MSB:0] ctrl_write_addr,
  input wire [31:0] ctrl_write_data,
  input wire [`LOC_MSB:0] ctrl_read_addr,
  output wire [31:0] ctrl_read_data,
  output wire sram_test_enable,
  output wire irq
);

  // ************************************************************
  // Registers
  // ************************************************************
  reg [31:0] dma_control;
  reg [`LOC_MSB:0] sram_location_field;
  reg [`IRQ_BITS-1:0] irq_status;
  reg [`IRQ_BITS-1:0] irq_mask;
  reg [`IRQ_BITS-1:0] next_irq_status;
  reg [31:0] next_prdata;
  reg mem_we;
  reg [`LOC_MSB:0] mem_wa;
  reg [31:0] mem_wd;
  reg [`LOC_MSB:0] mem_ra;
  wire access;
  wire wr;
  wire rd;
  wire sel_ctl;
  wire sel_adr;
  wire sel_dat;
  wire sel_sts;
  wire sel_msk;
  wire mapped;
  wire [31:0] sram_rdata;
  wire test_write;
  wire refused;

  // ************************************************************
  // APB decode
  // ************************************************************
  // Phase qualifiers; no wait states, so an access phase lasts one cycle
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;

  // Register selects on the full byte address
  assign sel_ctl = (paddr == `OFF_DMA_CONTROL);
  assign sel_adr = (paddr == `OFF_SRAM_TEST_ADDRESS);
  assign sel_dat = (paddr == `OFF_SRAM_TEST_DATA);
  assign sel_sts = (paddr == `OFF_IRQ_STATUS);
  assign sel_msk = (paddr == `OFF_IRQ_MASK);

  // Any other address answers with an error and changes nothing
  assign mapped = sel_ctl | sel_adr | sel_dat | sel_sts | sel_msk;

  assign sram_test_enable = dma_control[`BIT_TEST_ENABLE]; // see RULE_01
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign irq = |(irq_status & irq_mask);

  // Data register access is honoured only in test mode
  assign test_write = wr & sel_dat & sram_test_enable; // see RULE_03
  assign refused = access & sel_dat & ~sram_test_enable;

  // ************************************************************
  // SRAM port ownership
  // ************************************************************
  // Test mode owns the SRAM; clearing it hands back to the controller
  always @*
  begin
    if (sram_test_enable)
    begin
      mem_we = test_write;
      mem_wa = sram_location_field;
      mem_wd = pwdata;
      mem_ra = sram_location_field;
    end
    else
    begin
      mem_we = ctrl_write_en; // see RULE_05
      mem_wa = ctrl_write_addr;
      mem_wd = ctrl_write_data;
      mem_ra = ctrl_read_addr;
    end
  end

  sram_word_store u_store
  (
    .pclk(pclk),
    .write_en(mem_we),
    .write_addr(mem_wa),
    .write_data(mem_wd),
    .read_addr(mem_ra),
    .read_data(sram_rdata)
  );

  assign ctrl_read_data = sram_test_enable ? 32'h0000_0000 : sram_rdata;

  // ************************************************************
  // Register writes
  // ************************************************************
  // Control register; bit 13 hands the SRAM over to software
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_control <= `RST_DMA_CONTROL;
    end
    else if (wr & sel_ctl)
    begin
      dma_control <= pwdata; // see RULE_01
    end
  end

  // Location field; upper bits of the written word are dropped
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sram_location_field <= `RST_LOCATION;
    end
    else if (wr & sel_adr)
    begin
      sram_location_field <= pwdata[`LOC_MSB:0]; // see RULE_02
    end
  end

  // Interrupt mask, same layout as the status register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask <= `RST_IRQ_MASK;
    end
    else if (wr & sel_msk)
    begin
      irq_mask <= pwdata[`IRQ_BITS-1:0];
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Read mux; data word visible only in test mode
  always @*
  begin
    next_prdata = 32'h0000_0000;
    if (sel_ctl)
    begin
      next_prdata = dma_control;
    end
    else if (sel_adr)
    begin
      next_prdata = {22'h00_0000, sram_location_field};
    end
    else if (sel_dat)
    begin
      next_prdata = sram_test_enable ? sram_rdata : 32'h0000_0000; // see RULE_04
    end
    else if (sel_sts)
    begin
      next_prdata = {30'h0000_0000, irq_status};
    end
    else if (sel_msk)
    begin
      next_prdata = {30'h0000_0000, irq_mask};
    end
  end

  // Read data registered at the setup cycle so it is stable in access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel & ~penable & ~pwrite)
    begin
      prdata <= next_prdata;
    end
  end

  // ************************************************************
  // Interrupt status
  // ************************************************************
  // Sticky events: clear on status read, a new event wins over the clear
  always @*
  begin
    next_irq_status = irq_status;
    if (rd & sel_sts)
    begin
      next_irq_status = {`IRQ_BITS{1'b0}};
    end
    if (test_write)
    begin
      next_irq_status[`IRQ_BIT_WRITE_DONE] = 1'b1;
    end
    if (refused)
    begin
      next_irq_status[`IRQ_BIT_REFUSED] = 1'b1;
    end
  end

  // Status flops; the level output follows them through the mask
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= {`IRQ_BITS{1'b0}};
    end
    else
    begin
      irq_status <= next_irq_status;
    end
  end

endmodule // ether_sram_test_access

//--- tb/sram_access_properties.sv
// Checker for the packet SRAM test-access block, bound to its top ports.
// Assumes the single clock pclk and the async active-low reset presetn.
`timescale 1ns/10ps
module sram_access_properties
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire sram_test_enable,
  input wire [31:0] ctrl_read_data
);
  // ****
  // Write access and read setup phases
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  wire rs = psel && !penable && !pwrite;
  enable_bit_a: assert property (wr && paddr == 12'h000
    |=> sram_test_enable == $past(pwdata[13])) else $error("enable bit wrong");
  loc_read_a: assert property (wr && paddr == 12'h060 ##2 rs && paddr == 12'h060
    ##1 penable |-> prdata == {22'h00_0000, $past(pwdata[9:0], 3)}) else $error("bad location");
  data_pair_a: assert property (wr && paddr == 12'h064 && sram_test_enable ##2 rs
    && paddr == 12'h064 && sram_test_enable ##1 penable |-> prdata == $past(pwdata, 3))
    else $error("word read back wrong");
  refused_read_a: assert property (rs && paddr == 12'h064 && !sram_test_enable
    ##1 penable |-> prdata == 32'h0000_0000) else $error("refused read not zero");
  owner_switch_a: assert property (
    sram_test_enable |-> ctrl_read_data == 32'h0000_0000) else $error("controller sees data");
  cover property ($rose(sram_test_enable));
  cover property ($fell(sram_test_enable));
  cover property (wr && paddr == 12'h064 && sram_test_enable);
endmodule // sram_access_properties

//--- tb/tb.sv
// Self-checking bench for the packet SRAM test-access block over APB.
// Assumes the design, its defines header and the checker compile first.
`timescale 1ns/10ps
module tb;
  reg pclk, presetn, psel, penable, pwrite, ctrl_write_en, err;
  reg [11:0] paddr;
  reg [31:0] pwdata, ctrl_write_data, r, d;
  reg [9:0] ctrl_write_addr, ctrl_read_addr;
  wire pready, pslverr, sram_test_enable, irq;
  wire [31:0] prdata, ctrl_read_data;
  integer n_fail, total_checks, i, k;
  ether_sram_test_access ether_sram_test_access_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ctrl_write_en(ctrl_write_en),
    .ctrl_write_addr(ctrl_write_addr), .ctrl_write_data(ctrl_write_data),
    .ctrl_read_addr(ctrl_read_addr), .ctrl_read_data(ctrl_read_data),
    .sram_test_enable(sram_test_enable), .irq(irq));
  // Clock of 100 ns
  initial
  begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  // ****
  // Bus cycle, compare and closing tasks
  // ****
  task end_sim;
  begin
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task chk(input [31:0] g, input [31:0] e);
  begin
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  end
  endtask
  // Idle edge, setup, then access held until pready
  task apb(input w, input [11:0] a, input [31:0] v);
  begin
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      k = k + 1;
      @(posedge pclk);
    end
    if (k == 20)
    begin
      n_fail = n_fail + 1;
      end_sim;
    end
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  end
  endtask
  function [31:0] loc_of(input [31:0] v);
    loc_of = {22'h00_0000, v[9:0]};
  endfunction
  // ****
  // Main sequence
  // ****
  initial
  begin
    {presetn, psel, penable, pwrite, ctrl_write_en, err} = 0;
    {paddr, pwdata, ctrl_write_data, ctrl_write_addr, ctrl_read_addr} = 0;
    n_fail = 0;
    total_checks = 0;
    r = $urandom(32'hf962);
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0);
    chk(r, 0);
    apb(1, 12'h074, 32'h0000_0002);
    ctrl_write_en <= 1;
    d = $urandom;
    ctrl_write_addr <= d[9:0];
    ctrl_write_data <= $urandom;
    apb(0, 12'h064, 0);
    chk(r, 0);
    @(posedge pclk);
    chk({31'h0, irq}, 1);
    apb(0, 12'h070, 0);
    chk(r, 32'h0000_0002);
    @(posedge pclk);
    chk({31'h0, irq}, 0);
    ctrl_write_en <= 0;
    $display("refusal and interrupt test done");
    apb(1, 12'h000, 32'h0000_2000);
    @(posedge pclk);
    chk({31'h0, sram_test_enable}, 1);
    apb(1, 12'h060, loc_of(ctrl_write_addr));
    apb(0, 12'h064, 0);
    chk(r, ctrl_write_data);
    for (i = 0; i < 12; i = i + 1)
    begin
      d = $urandom;
      d[9:0] = i == 0 ? 10'h000 : (i == 1 ? 10'h3ff : d[9:0]);
      apb(1, 12'h060, d);
      apb(0, 12'h060, 0);
      chk(r, loc_of(d));
      d = $urandom;
      apb(1, 12'h064, d);
      apb(0, 12'h064, 0);
      chk(r, d);
    end
    chk({31'h0, irq}, 0);
    apb(1, 12'h074, 32'h0000_0003);
    @(posedge pclk);
    chk({31'h0, irq}, 1);
    apb(0, 12'h070, 0);
    chk(r, 32'h0000_0001);
    $display("random word test done");
    for (i = 0; i < 1024; i = i + 1)
    begin
      apb(1, 12'h060, i);
      apb(1, 12'h064, 0);
      apb(0, 12'h064, 0);
      chk(r, 0);
    end
    apb(1, 12'h000, 0);
    @(posedge pclk);
    chk({31'h0, sram_test_enable}, 0);
    ctrl_read_addr <= ctrl_write_addr;
    apb(0, 12'h010, 0);
    chk({31'h0, err}, 1);
    chk(ctrl_read_data, 0);
    $display("clear and release test done");
    end_sim;
  end
endmodule // tb
bind ether_sram_test_access sram_access_properties sram_access_properties_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .sram_test_enable(sram_test_enable),
  .ctrl_read_data(ctrl_read_data));
